/* design/adc_ctl_pkg.sv */
// Constants, register map and types shared by the converter control block.
package adc_ctl_pkg;

    // Clock and conversion timing.
    localparam int CLK_PERIOD_NS = 20;
    localparam int CONV_TIME_NS  = 1450;
    localparam int CONV_CYCLES_I =
        (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W         = 7;
    localparam logic [CNT_W-1:0] CONV_CYCLES = CONV_CYCLES_I[CNT_W-1:0];
    localparam logic [CNT_W-1:0] CNT_ONE     = 7'h01;
    localparam logic [CNT_W-1:0] CNT_ZERO    = 7'h00;

    // Register bus geometry.
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] OFS_CTRL   = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_COUNT  = 4'h8;

    // Control register fields.
    localparam int CTRL_CFG_REG_BIT = 0;
    localparam int CTRL_PD_BIT      = 1;
    localparam logic [1:0] CTRL_RESET = 2'h0;

    // Status register fields.
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_PD_BIT   = 1;
    localparam int ST_REF_BIT  = 2;
    localparam int ST_BUF_BIT  = 3;
    localparam int ST_TEMP_BIT = 4;
    localparam int ST_FULL_BIT = 5;

    // Conversion counter.
    localparam int COUNT_W = 16;
    localparam logic [COUNT_W-1:0] COUNT_ONE = 16'h0001;
    localparam logic [COUNT_W-1:0] COUNT_RST = 16'h0000;
    localparam logic [DATA_W-1:0]  DATA_ZERO = 32'h0000_0000;

    // Conversion sequencer states, Gray coded from idle through done; the return from done to idle flips both bits.
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CONV = 2'b01,
        ST_DONE = 2'b11
    } conv_state_t;

endpackage

/* design/adc_power_ctl.sv */
// Conversion start, power down and reference mode control with APB access.
`timescale 1ns/100ps
`default_nettype none
module adc_power_ctl (
    input  wire logic                       clk_sys,           // Clock.
    input  wire logic                       sys_rst,           // Reset.
    input  wire logic                       conversion_start_n,// Start.
    input  wire logic                       power_down_pin,    // Power down.
    input  wire logic                       internal_source_off,// Ref off.
    input  wire logic                       buffer_off,        // Buf off.
    input  wire logic                       psel,              // APB sel.
    input  wire logic                       penable,           // APB enable.
    input  wire logic                       pwrite,            // APB write.
    input  wire logic [adc_ctl_pkg::ADDR_W-1:0] paddr,         // APB addr.
    input  wire logic [adc_ctl_pkg::DATA_W-1:0] pwdata,        // APB wdata.
    output logic      [adc_ctl_pkg::DATA_W-1:0] prdata,        // APB rdata.
    output logic                            pready,            // APB ready.
    output logic                            pslverr,           // APB error.
    output logic                            busy,              // Converting.
    output logic                            conv_done,         // End pulse.
    output logic                            powered_down,      // Min current.
    output logic                            analog_full_power, // Core on.
    output logic                            acq_low_power,     // Reduced.
    output logic                            internal_ref_en,   // Bandgap on.
    output logic                            ref_buffer_en,     // Buffer on.
    output logic                            temp_sensor_en     // Sensor on.
);
    import adc_ctl_pkg::*;

    // Start, busy and done travel to and from the sequencer in one bundle.
    conv_if cv ();

    logic               start_prev_q;
    logic [1:0]         ctrl_q;
    logic [COUNT_W-1:0] count_q;
    logic [DATA_W-1:0]  rdata_q;
    logic               pd_state_q;
    logic               full_q;
    logic               low_q;
    logic               ref_q;
    logic               buf_q;
    logic               temp_q;

    wire                start_fall;
    wire                pd_effective;
    wire                cfg_from_reg;
    wire                pd_bit;
    wire                setup_phase;
    wire                access_phase;
    wire                sel_ctrl;
    wire                sel_status;
    wire                sel_count;
    wire                addr_hit;
    wire                wr_ctrl;
    wire [DATA_W-1:0]   status_word;
    wire [DATA_W-1:0]   rdata_d;

    // Start edge detector; no chip-select or read-enable takes part.
    assign start_fall = start_prev_q && !conversion_start_n;

    // Power down source: register bit in register mode, else the pin.
    assign cfg_from_reg = ctrl_q[CTRL_CFG_REG_BIT];
    assign pd_bit       = ctrl_q[CTRL_PD_BIT];
    assign pd_effective = cfg_from_reg ? pd_bit : power_down_pin;

    // While powered down no new conversion starts; a running one is kept.
    assign cv.start = start_fall && !pd_effective;

    conv_sequencer u_seq (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .cv      (cv)
    );

    // Start edge history; reset to high so reset release is not an edge.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            start_prev_q <= 1'b1;
        end else begin
            start_prev_q <= conversion_start_n;
        end
    end

    // Analog power states: full only while converting, off in power down.
    // Power down waits for busy to fall, so no conversion is cut short.
    // The drop to low power after a conversion needs no host request.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            pd_state_q <= 1'b0;
            full_q     <= 1'b0;
            low_q      <= 1'b1;
        end else begin
            pd_state_q <= pd_effective && !cv.busy;
            full_q     <= cv.busy;
            low_q      <= !cv.busy && !pd_effective;
        end
    end

    // Reference chain: each input gates its own element and the sensor.
    // The enables ignore power down; only their own inputs count.
    // The sensor needs the whole internal chain, source and buffer alike.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            ref_q  <= 1'b0;
            buf_q  <= 1'b0;
            temp_q <= 1'b0;
        end else begin
            ref_q  <= !internal_source_off;
            buf_q  <= !buffer_off;
            temp_q <= !internal_source_off && !buffer_off;
        end
    end

    // Completed conversion counter for software.
    // It wraps silently; software reads it as a running total.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            count_q <= COUNT_RST;
        end else if (cv.done) begin
            count_q <= count_q + COUNT_ONE;
        end
    end

    // APB decode; the bus never looks at the power state.
    // The bus answers at once in every power state, so pready is tied high.
    // Unmapped addresses raise pslverr in the access phase only.
    assign setup_phase  = psel && !penable;
    assign access_phase = psel && penable;
    assign sel_ctrl     = (paddr == OFS_CTRL);
    assign sel_status   = (paddr == OFS_STATUS);
    assign sel_count    = (paddr == OFS_COUNT);
    assign addr_hit     = sel_ctrl || sel_status || sel_count;
    assign wr_ctrl      = access_phase && pwrite && sel_ctrl;
    assign pready       = 1'b1;
    assign pslverr      = access_phase && !addr_hit;

    // Status word and read mux; unmapped reads return zero.
    assign status_word = {{(DATA_W-6){1'b0}}, full_q, temp_q, buf_q, ref_q,
                          pd_state_q, cv.busy};
    assign rdata_d = sel_ctrl   ? {{(DATA_W-2){1'b0}}, ctrl_q} :
                     sel_status ? status_word :
                     sel_count  ? {{(DATA_W-COUNT_W){1'b0}}, count_q} :
                                  DATA_ZERO;

    // Control register write.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            ctrl_q <= CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_q <= pwdata[1:0];
        end
    end

    // Read data captured in the setup cycle, held through the access.
    // Capturing at setup keeps prdata steady for the whole access phase.
    // A status read therefore shows the state one cycle before the access.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            rdata_q <= DATA_ZERO;
        end else if (setup_phase) begin
            rdata_q <= rdata_d;
        end
    end

    // Output assignments.
    assign prdata            = rdata_q;
    assign busy              = cv.busy;
    assign conv_done         = cv.done;
    assign powered_down      = pd_state_q;
    assign analog_full_power = full_q;
    assign acq_low_power     = low_q;
    assign internal_ref_en   = ref_q;
    assign ref_buffer_en     = buf_q;
    assign temp_sensor_en    = temp_q;

    // Checks on power and reference control.
    // Most compare a registered output with the inputs one edge earlier,
    // because every power and reference output lags by one cycle.
    pd_keeps_conv_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        cv.busy && pd_effective |=> !pd_state_q)
        else $error("power down entered during a conversion");

    pd_enter_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        pd_effective && !cv.busy |=> pd_state_q && !full_q)
        else $error("power down not entered while idle");

    sw_pd_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        cfg_from_reg && pd_bit && !cv.busy ##1 cfg_from_reg && pd_bit
        |-> pd_state_q)
        else $error("register power down had no effect");

    pin_ignored_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        cfg_from_reg && !pd_bit && power_down_pin |=> !pd_state_q)
        else $error("pin level acted in register mode");

    start_fall_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        $fell(conversion_start_n) && !pd_effective && !cv.busy
        && !cv.done |=> busy)
        else $error("falling start edge did not start a conversion");

    ref_internal_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !internal_source_off && !buffer_off
        |=> ref_q && buf_q && temp_q)
        else $error("internal reference mode not fully enabled");

    ref_extbuf_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        internal_source_off && !buffer_off
        |=> !ref_q && buf_q && !temp_q)
        else $error("buffered external mode wrong");

    ref_direct_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        internal_source_off && buffer_off
        |=> !ref_q && !buf_q && !temp_q)
        else $error("direct external mode wrong");

    buf_alone_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !internal_source_off && buffer_off |=> ref_q && !buf_q)
        else $error("reference inputs not independent");

    temp_gate_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        temp_q |-> ref_q && buf_q)
        else $error("sensor on outside internal reference mode");

    acq_drop_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        $fell(cv.busy) |=> !full_q ##1 !full_q)
        else $error("analog power not reduced after conversion");

    bus_alive_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        access_phase && (pd_state_q || low_q) |-> pready)
        else $error("bus stalled in a low power state");

    // Checks on the register bus; none of them looks at the power state.
    bus_ok_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        access_phase && addr_hit |-> !pslverr)
        else $error("error flagged on a mapped register");

    bus_err_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        access_phase && !addr_hit
        |-> pslverr && prdata == DATA_ZERO)
        else $error("unmapped access not refused");

    ctrl_read_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        access_phase && !pwrite && sel_ctrl
        |-> prdata == {{(DATA_W-2){1'b0}}, ctrl_q})
        else $error("control read does not match the register");

    ctrl_set_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        wr_ctrl && pwdata[CTRL_CFG_REG_BIT] && pwdata[CTRL_PD_BIT]
        |=> cfg_from_reg && pd_bit)
        else $error("control write did not set both bits");

    ctrl_clr_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        wr_ctrl && !pwdata[CTRL_CFG_REG_BIT] && !pwdata[CTRL_PD_BIT]
        |=> !cfg_from_reg && !pd_bit)
        else $error("control write did not clear both bits");

    ctrl_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !wr_ctrl |=> $stable(ctrl_q))
        else $error("control register changed without a write");

    // Checks on the conversion counter and the analog power outputs.
    count_step_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        cv.done |=> count_q == $past(count_q) + COUNT_ONE)
        else $error("finished conversion not counted");

    count_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !cv.done |=> $stable(count_q))
        else $error("counter moved without a finished conversion");

    full_follow_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        cv.busy |=> full_q)
        else $error("analog core not at full power while converting");

    acq_low_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !cv.busy && !pd_effective |=> low_q && !pd_state_q)
        else $error("low power acquisition state not entered");

    low_not_full_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        low_q |-> !full_q)
        else $error("low and full power shown together");

    sleep_no_start_a: assert property (@(posedge clk_sys)
        disable iff (sys_rst) pd_effective && start_fall && !cv.busy
        |=> !cv.busy)
        else $error("conversion started while powered down");

    pd_during_conv_c: cover property (@(posedge clk_sys)
        disable iff (sys_rst) cv.busy && pd_effective ##1 cv.busy);

    sw_mode_c: cover property (@(posedge clk_sys) disable iff (sys_rst)
        cfg_from_reg && pd_bit && pd_state_q);

    direct_ref_c: cover property (@(posedge clk_sys) disable iff (sys_rst)
        !ref_q && !buf_q);

endmodule // adc_power_ctl
`default_nettype wire

/* design/conv_if.sv */
// Handshake between the control top and the conversion sequencer.
`timescale 1ns/100ps
`default_nettype none
interface conv_if;
    logic start;   // One-cycle request to launch a conversion.
    logic busy;    // High while a conversion runs.
    logic done;    // One-cycle pulse after the last conversion cycle.

    modport ctl (output start, input busy, input done);
    modport eng (input start, output busy, output done);
endinterface
`default_nettype wire

/* design/conv_sequencer.sv */
// Conversion sequencer: runs each conversion to its full length.
`timescale 1ns/100ps
`default_nettype none
module conv_sequencer (
    input  wire logic clk_sys,   // System clock.
    input  wire logic sys_rst,   // Synchronous reset, active high.
    conv_if.eng       cv         // Start request and status.
);
    import adc_ctl_pkg::*;

    conv_state_t      state_q;
    conv_state_t      state_d;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    wire              take_start;

    // A start is taken only from idle, so later edges are dropped.
    assign take_start = cv.start && (state_q == ST_IDLE);
    assign cv.busy    = (state_q == ST_CONV);
    assign cv.done    = (state_q == ST_DONE);

    // Next state; nothing leaves a running conversion but its own count.
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        case (state_q)
            ST_IDLE: begin
                if (take_start) begin
                    state_d = ST_CONV;
                    cnt_d   = CONV_CYCLES - CNT_ONE;
                end
            end
            ST_CONV: begin
                if (cnt_q == CNT_ZERO) begin
                    state_d = ST_DONE;
                end else begin
                    cnt_d = cnt_q - CNT_ONE;
                end
            end
            ST_DONE: state_d = ST_IDLE;
            default: state_d = ST_IDLE;
        endcase
    end

    // State registers.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state_q <= ST_IDLE;
            cnt_q   <= CNT_ZERO;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
        end
    end

    // Checks on the sequencer.
    start_to_busy_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        take_start |=> cv.busy)
        else $error("start from idle did not raise busy");
    conv_length_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        $rose(cv.busy) |-> ##72 cv.busy ##1 !cv.busy)
        else $error("conversion length is not 73 cycles");
    no_restart_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        cv.busy && cv.start && cnt_q != CNT_ZERO
        |=> cv.busy && cnt_q == $past(cnt_q) - CNT_ONE)
        else $error("start during conversion disturbed the count");
    busy_done_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
        $fell(cv.busy) |-> cv.done ##1 !cv.done)
        else $error("end of conversion not flagged by done pulse");

    conv_seen_c: cover property (@(posedge clk_sys) disable iff (sys_rst)
        cv.busy ##1 cv.done);
    restart_try_c: cover property (@(posedge clk_sys) disable iff (sys_rst)
        cv.busy && cv.start);

endmodule // conv_sequencer
`default_nettype wire

/* verification/adc_conversion_power_control_tb_top.sv */
// Self-checking bench for the converter control block.
`timescale 1ns/100ps
`default_nettype none
module adc_conversion_power_control_tb_top;
    import adc_ctl_pkg::*;
    logic              clk_sys, sys_rst, psel, penable, pwrite, err;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata, rd, e;
    logic              pready, pslverr, busy, conv_done, powered_down;
    logic              analog_full_power, acq_low_power;
    logic              internal_ref_en, ref_buffer_en, temp_sensor_en;
    wire logic         start_n, pd_pin, src_off, buf_off;
    int                n_errors, compares, run_len, last_len, dones, cnt;

    host_model host_u (.clk_sys(clk_sys), .conversion_start_n(start_n),
        .power_down_pin(pd_pin), .internal_source_off(src_off),
        .buffer_off(buf_off));

    adc_power_ctl dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .conversion_start_n(start_n), .power_down_pin(pd_pin),
        .internal_source_off(src_off), .buffer_off(buf_off),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .busy(busy), .conv_done(conv_done),
        .powered_down(powered_down), .analog_full_power(analog_full_power),
        .acq_low_power(acq_low_power), .internal_ref_en(internal_ref_en),
        .ref_buffer_en(ref_buffer_en), .temp_sensor_en(temp_sensor_en));

    // Free-running 50 MHz clock.
    always #10 clk_sys = ~clk_sys;

    // Measures each busy run length and counts done pulses.
    always @(posedge clk_sys) begin
        if (busy === 1'b1) begin
            run_len <= run_len + 1;
        end else if (run_len != 0) begin
            last_len <= run_len;
            run_len  <= 0;
        end
        if (conv_done === 1'b1) begin
            dones <= dones + 1;
        end
    end

    // Compares one value and records any mismatch.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string msg);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: %s got %h exp %h",
                     $time, msg, got, exp);
        end
    endtask

    // One APB transfer; waits for pready as long as the watchdog allows.
    task automatic apb(input logic [ADDR_W-1:0] a, input logic w,
                       input logic [DATA_W-1:0] wd);
        @(posedge clk_sys);
        psel    <= 1'b1;
        penable <= 1'b0;
        paddr   <= a;
        pwrite  <= w;
        pwdata  <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        chk({31'h0, pready}, 32'h1, "ready in access");
    endtask

    // Lets two edges pass so lagging outputs settle.
    task automatic settle();
        repeat (2) @(posedge clk_sys);
        #1;
    endtask

    // Waits for busy to drop, bounded, then lets the monitor update.
    task automatic wait_idle();
        int i;
        for (i = 0; i < 300; i++) begin
            @(posedge clk_sys);
            #1;
            if (busy === 1'b0) break;
        end
        if (i == 300) chk(32'h1, 32'h0, "busy never dropped");
        settle();
    endtask

    // Prints the counts and the verdict, then stops.
    task automatic end_of_test();
        $display("Checks made %0d, mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Cuts a hang short after far more time than the tests need.
    initial begin
        #100000;
        n_errors++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        end_of_test();
    end

    // Test sequence.
    initial begin
        clk_sys = 1'b0;
        sys_rst = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {n_errors, compares, run_len, last_len, dones, cnt} = '0;
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        apb(OFS_CTRL, 1'b0, DATA_ZERO);
        chk(rd, 32'h0, "ctrl reset");
        apb(4'hc, 1'b1, 32'hffff_ffff);
        chk({31'h0, err}, 32'h1, "unmapped write error");
        apb(4'hc, 1'b0, DATA_ZERO);
        chk({31'h0, err}, 32'h1, "unmapped read error");
        chk(rd, 32'h0, "unmapped read data");
        apb(OFS_COUNT, 1'b1, 32'h1234);
        apb(OFS_COUNT, 1'b0, DATA_ZERO);
        chk(rd, 32'h0, "count reset and read only");
        $display("Test registers finished");

        host_u.start_pulse();
        apb(OFS_STATUS, 1'b0, DATA_ZERO);
        chk(rd, 32'h3d, "status while converting");
        chk({31'h0, acq_low_power}, 32'h0, "acq off while busy");
        host_u.start_pulse();
        wait_idle();
        chk(last_len, 32'd73, "busy length with restart");
        cnt++;
        chk(dones, cnt, "no queued conversion");
        chk({31'h0, acq_low_power}, 32'h1, "low power after end");
        chk({31'h0, analog_full_power}, 32'h0, "full power off");
        host_u.start_pulse();
        wait_idle();
        cnt++;
        chk(dones, cnt, "back to back done");
        apb(OFS_COUNT, 1'b0, DATA_ZERO);
        chk(rd, cnt, "count two");
        $display("Test conversion finished");

        host_u.start_pulse();
        host_u.set_pins(1'b1, 1'b0, 1'b0);
        #1;
        chk({31'h0, busy}, 32'h1, "still busy at pd");
        wait_idle();
        chk(last_len, 32'd73, "pd does not abort");
        cnt++;
        chk({31'h0, powered_down}, 32'h1, "pin power down");
        apb(OFS_STATUS, 1'b0, DATA_ZERO);
        chk(rd, 32'h1e, "bus alive in pd");
        host_u.start_pulse();
        settle();
        chk({31'h0, busy}, 32'h0, "no start in pd");
        $display("Test pin power down finished");

        apb(OFS_CTRL, 1'b1, 32'hffff_ffff);
        apb(OFS_CTRL, 1'b0, DATA_ZERO);
        chk(rd, 32'h3, "ctrl fields");
        apb(OFS_CTRL, 1'b1, 32'h1);
        settle();
        chk({31'h0, powered_down}, 32'h0, "pin ignored");
        host_u.set_pins(1'b0, 1'b0, 1'b0);
        apb(OFS_CTRL, 1'b1, 32'h3);
        settle();
        chk({31'h0, powered_down}, 32'h1, "register pd");
        apb(OFS_CTRL, 1'b1, 32'h0);
        settle();
        chk({31'h0, powered_down}, 32'h0, "pd released");
        apb(OFS_CTRL, 1'b1, 32'h2);
        settle();
        chk({31'h0, powered_down}, 32'h0, "bit alone ignored");
        apb(OFS_COUNT, 1'b0, DATA_ZERO);
        chk(rd, cnt, "count after pd");
        $display("Test register power down finished");

        for (int m = 0; m < 4; m++) begin
            host_u.set_pins(1'b0, m[0], m[1]);
            settle();
            e = DATA_ZERO;
            e[ST_REF_BIT]  = ~m[0];
            e[ST_BUF_BIT]  = ~m[1];
            e[ST_TEMP_BIT] = (m == 0);
            chk({31'h0, internal_ref_en}, e[ST_REF_BIT], "ref");
            chk({31'h0, ref_buffer_en}, e[ST_BUF_BIT], "buffer");
            chk({31'h0, temp_sensor_en}, e[ST_TEMP_BIT], "temp");
            apb(OFS_STATUS, 1'b0, DATA_ZERO);
            chk(rd, e, "reference mode status");
        end
        $display("Test reference modes finished");
        end_of_test();
    end
endmodule // adc_conversion_power_control_tb_top
`default_nettype wire

/* verification/host_model.sv */
// Host model driving the converter start and static control pins.
`timescale 1ns/100ps
`default_nettype none
module host_model (
    input  wire logic clk_sys,             // System clock.
    output logic      conversion_start_n,  // Start, active low.
    output logic      power_down_pin,      // Power down level.
    output logic      internal_source_off, // Reference source off.
    output logic      buffer_off           // Reference buffer off.
);
    // Idle levels from time zero: start high, all pins low.
    initial begin
        conversion_start_n  = 1'b1;
        power_down_pin      = 1'b0;
        internal_source_off = 1'b0;
        buffer_off          = 1'b0;
    end

    // One falling edge, held low across exactly one sampling edge.
    task automatic start_pulse();
        @(posedge clk_sys);
        conversion_start_n <= 1'b0;
        @(posedge clk_sys);
        conversion_start_n <= 1'b1;
    endtask

    // Static pins move only after an edge and then stay at a fixed level.
    task automatic set_pins(input logic pd, input logic src, input logic bo);
        @(posedge clk_sys);
        power_down_pin      <= pd;
        internal_source_off <= src;
        buffer_off          <= bo;
    endtask
endmodule // host_model
`default_nettype wire
